/* press_timer.sv */
// module: power switch debouncer and press length classifier
`timescale 1ns/1ps
`default_nettype none
module press_timer
	import pwr_state_pkg::*;
#(
	parameter int unsigned DEB_CYC  = DEBOUNCE_CYC,
	parameter int unsigned LONG_CYC = LONG_PRESS_CYC
) (
	// clock and reset
	input  wire logic core_clk_i,
	input  wire logic resetn_i,
	// synchronised switch level, high while pressed
	input  wire logic sw_i,
	// classified presses
	output logic      short_o,
	output logic      long_o
);
	logic [31:0] deb_cnt;
	logic        stable;
	logic        stable_q;
	logic [31:0] press_cnt;
	logic        long_done;

	// debounce: level must hold DEB_CYC cycles before it is believed
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			deb_cnt <= '0;
			stable  <= 1'b0;
		end else if (sw_i == stable) begin
			deb_cnt <= '0;
		end else if (deb_cnt >= DEB_CYC - 1) begin
			deb_cnt <= '0;
			stable  <= sw_i;
		end else begin
			deb_cnt <= deb_cnt + 32'h0000_0001;
		end
	end

	// press length count and decision, at threshold or release
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			stable_q  <= 1'b0;
			press_cnt <= '0;
			long_done <= 1'b0;
			short_o   <= 1'b0;
			long_o    <= 1'b0;
		end else begin
			stable_q <= stable;
			short_o  <= 1'b0;
			long_o   <= 1'b0;
			if (stable && !stable_q) begin
				press_cnt <= 32'h0000_0001;
				long_done <= 1'b0;
			end else if (stable && !long_done) begin
				if (press_cnt >= LONG_CYC - 1) begin
					long_o    <= 1'b1;
					long_done <= 1'b1;
				end else begin
					press_cnt <= press_cnt + 32'h0000_0001;
				end
			end else if (!stable && stable_q && !long_done) begin
				short_o <= 1'b1;
			end
		end
	end
endmodule : press_timer
`default_nettype wire

/* pwr_state_ctrl.sv */
// module: system power state and wake source controller
// What this block does
// - short press: off to on, on/sleep toggle
// - long press forces soft-off from on/sleep
// - closed cover switch latches intrusion flag
// - switch, alarm, express wake wake any sleep
// - ring, PS/2, USB wake S1/S3 only
// - LAN, PME wake S1-S4; S5 needs enable
`timescale 1ns/1ps
`default_nettype none
module pwr_state_ctrl
	import pwr_state_pkg::*;
#(
	parameter int unsigned DEB_CYC  = DEBOUNCE_CYC,
	parameter int unsigned LONG_CYC = LONG_PRESS_CYC
) (
	// clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       resetn_i,
	// front panel switch, low while pressed
	input  wire logic       pwr_sw_n_i,
	// chassis cover switch, high when closed
	input  wire logic       cover_closed_i,
	// asynchronous wake sources
	input  wire wake_src_t  wake_i,
	// os power request
	input  wire os_req_t    os_req_i,
	// intrusion flag clear
	input  wire logic       intr_clr_i,
	// configuration: lan/pme wake from soft-off, short press target
	input  wire logic       lan_s5_en_i,
	input  wire sys_state_t sleep_level_i,
	// status
	output sys_state_t      state_o,
	output logic            main_pwr_on_o,
	output logic            wake_evt_o,
	output logic            intrusion_o
);
	// synchroniser stages; logic reads only the second stage of each
	logic       sw_m;
	logic       sw_s;
	logic       cov_m;
	logic       cov_s;
	wake_src_t  wk_m;
	wake_src_t  wk_s;
	// registered configuration and classified presses
	logic       lan_s5_en;
	logic       short_p;
	logic       long_p;
	// wake sources grouped by the deepest sleep that each may end
	logic       deep_wake;
	logic       shallow_wake;
	logic       net_wake;
	// qualified wake and state decode
	logic       wake_ok;
	sys_state_t next_state;

	// states in which the main rails are up; fans and core supply follow this
	function automatic logic is_powered(input sys_state_t st);
		return (st == ST_S0) || (st == ST_S1);
	endfunction : is_powered

	// states that a qualified wake may return to working
	function automatic logic is_asleep(input sys_state_t st);
		return (st == ST_S1) || (st == ST_S3) || (st == ST_S4) || (st == ST_S5);
	endfunction : is_asleep

	// may the grouped sources end the given sleep level
	function automatic logic wake_allowed(
		input sys_state_t st,
		input logic       deep,
		input logic       shallow,
		input logic       net,
		input logic       net_s5_en
	);
		logic ok;
		ok = 1'b0;
		case (st)
			ST_S1, ST_S3: ok = deep | shallow | net;
			ST_S4:        ok = deep | net;
			ST_S5:        ok = deep | (net & net_s5_en);
			default:      ok = 1'b0;
		endcase
		return ok;
	endfunction : wake_allowed

	// the switch, cover and wake pins pass two flops before logic reads them; reset values match
	// each pin's idle level, so no false press or wake follows reset.
	// switch synchroniser, inverted so that high means pressed from here on
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			sw_m <= 1'b0;
			sw_s <= 1'b0;
		end else begin
			sw_m <= ~pwr_sw_n_i;
			sw_s <= sw_m;
		end
	end

	// cover switch synchroniser; the contact may move at any time
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			cov_m <= 1'b0;
			cov_s <= 1'b0;
		end else begin
			cov_m <= cover_closed_i;
			cov_s <= cov_m;
		end
	end

	// wake source synchronisers; each source is an unrelated level
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			wk_m <= '0;
			wk_s <= '0;
		end else begin
			wk_m <= wake_i;
			wk_s <= wk_m;
		end
	end

	// configuration enable, cleared by reset so that soft-off
	// ignores the network until software asks otherwise
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i)
			lan_s5_en <= LAN_S5_EN_RST;
		else
			lan_s5_en <= lan_s5_en_i;
	end

	// debounce and press timing kept apart so their counters size alone
	press_timer #(
		.DEB_CYC  (DEB_CYC),
		.LONG_CYC (LONG_CYC)
	) u_press (
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.sw_i       (sw_s),
		.short_o    (short_p),
		.long_o     (long_p)
	);

	// group the synchronised sources; the switch itself wakes
	// through the press path, not here
	always_comb begin
		deep_wake    = wk_s.rtc | wk_s.pcie_wake;
		shallow_wake = wk_s.ring | wk_s.ps2 | wk_s.usb;
		net_wake     = wk_s.lan | wk_s.pci_pme;
	end

	// only sources allowed for the present level count; working never qualifies
	always_comb begin
		wake_ok = wake_allowed(state_o, deep_wake, shallow_wake, net_wake, lan_s5_en);
	end

	// next state: long press beats short press, which beats wake and os request.
	// the os may only move the system out of working; every return to working
	// comes from a press or a qualified wake
	always_comb begin
		next_state = state_o;
		case (state_o)
			// working: a short press enters the chosen sleep level
			ST_S0: begin
				if (long_p)
					next_state = ST_S5;
				else if (short_p)
					next_state = (sleep_level_i == ST_S0) ? ST_S1 : sleep_level_i;
				else if (os_req_i.valid)
					next_state = os_req_i.target;
			end
			// sleeping: a wake or short press returns, a long press powers off
			ST_S1, ST_S3, ST_S4: begin
				if (long_p)
					next_state = ST_S5;
				else if (short_p || wake_ok)
					next_state = ST_S0;
			end
			// soft-off: a long press is ignored and its release makes no short press
			ST_S5: begin
				if (short_p || wake_ok)
					next_state = ST_S0;
			end
			default: next_state = STATE_RST;
		endcase
	end

	// state register; moves only on presses, qualified wakes or os requests
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i)
			state_o <= STATE_RST;
		else
			state_o <= next_state;
	end

	// rail enable follows the next state so it changes with state_o, not after it
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i)
			main_pwr_on_o <= 1'b0;
		else
			main_pwr_on_o <= is_powered(next_state);
	end

	// one-cycle wake report, raised on the edge that leaves the sleep level
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i)
			wake_evt_o <= 1'b0;
		else
			wake_evt_o <= wake_ok && is_asleep(state_o);
	end

	// intrusion flag: set wins over clear, so a cover still closed keeps
	// the flag up whatever software writes
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i)
			intrusion_o <= 1'b0;
		else if (cov_s)
			intrusion_o <= 1'b1;
		else if (intr_clr_i)
			intrusion_o <= 1'b0;
	end
endmodule : pwr_state_ctrl
`default_nettype wire

/* pwr_state_ctrl_chk.sv */
// checker: port assertions for the power state controller
`timescale 1ns/1ps
`default_nettype none
module pwr_state_ctrl_chk
	import pwr_state_pkg::*;
#(parameter int unsigned DEB_CYC = 4, LONG_CYC = 50) (
	// watched ports
	input wire logic       core_clk_i, resetn_i, pwr_sw_n_i, cover_closed_i, intr_clr_i,
	input wire logic       lan_s5_en_i, main_pwr_on_o, wake_evt_o, intrusion_o,
	input wire wake_src_t  wake_i,
	input wire os_req_t    os_req_i,
	input wire sys_state_t state_o
);
	localparam int LP = LONG_CYC + DEB_CYC + 8;
	int held;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	// raw press length; sync and debounce fit in the spare cycles
	always_ff @(posedge core_clk_i) held <= pwr_sw_n_i ? 0 : held + 1;
	// deep sleep with nothing present that may wake it
	sequence deep_idle;
		state_o inside {ST_S4, ST_S5} && !wake_i.rtc && !wake_i.pcie_wake && pwr_sw_n_i &&
			(!(wake_i.lan || wake_i.pci_pme) || state_o == ST_S5 && !lan_s5_en_i);
	endsequence
	sequence rtc_asleep;
		state_o != ST_S0 && wake_i.rtc;
	endsequence
	a_reset_vals: assert property (disable iff (1'b0) !resetn_i |=>
		state_o == ST_S5 && !intrusion_o && !wake_evt_o) else $error("bad reset value");
	a_main_pwr: assert property (main_pwr_on_o == (state_o inside {ST_S0, ST_S1}))
		else $error("main power wrong");
	a_long_off: assert property (held == LP |-> state_o == ST_S5)
		else $error("long press not off");
	a_rtc_wake: assert property (rtc_asleep [*2] |-> ##[1:3] state_o == ST_S0)
		else $error("alarm did not wake");
	// sixteen quiet cycles cover sync, debounce and the release of a press
	a_deep_ignore: assert property (deep_idle [*8] ##1 deep_idle [*8] |=>
		$stable(state_o)) else $error("unqualified wake");
	a_intr_set: assert property (cover_closed_i [*4] |=> intrusion_o)
		else $error("intrusion not set");
	a_intr_hold: assert property (intrusion_o && !intr_clr_i |=> intrusion_o)
		else $error("intrusion lost");
	a_os_leave: assert property (os_req_i.valid && state_o == ST_S0 &&
		os_req_i.target != ST_S0 |-> ##[1:3] state_o != ST_S0) else $error("os request lost");
endmodule : pwr_state_ctrl_chk
bind pwr_state_ctrl pwr_state_ctrl_chk #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC)) u_chk (
	.core_clk_i     (core_clk_i),
	.resetn_i       (resetn_i),
	.pwr_sw_n_i     (pwr_sw_n_i),
	.cover_closed_i (cover_closed_i),
	.intr_clr_i     (intr_clr_i),
	.lan_s5_en_i    (lan_s5_en_i),
	.main_pwr_on_o  (main_pwr_on_o),
	.wake_evt_o     (wake_evt_o),
	.intrusion_o    (intrusion_o),
	.wake_i         (wake_i),
	.os_req_i       (os_req_i),
	.state_o        (state_o)
);
`default_nettype wire

/* pwr_state_pkg.sv */
// package: power states, timing constants and carrier structs for the power state controller
package pwr_state_pkg;

	// system power states
	typedef enum logic [2:0] {
		ST_S0,
		ST_S1,
		ST_S3,
		ST_S4,
		ST_S5
	} sys_state_t;

	// clock and press timing
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned LONG_PRESS_MS   = 4000;
	localparam int unsigned DEBOUNCE_MS     = 20;
	localparam int unsigned LONG_PRESS_CYC  = (LONG_PRESS_MS / 1000) * CLK_HZ;
	localparam int unsigned DEBOUNCE_CYC    = (CLK_HZ / 1000) * DEBOUNCE_MS;

	// reset values
	localparam logic        LAN_S5_EN_RST   = 1'b0;
	localparam sys_state_t  STATE_RST       = ST_S5;

	// wake source bundle, all asynchronous levels
	typedef struct packed {
		logic rtc;
		logic pcie_wake;
		logic pci_pme;
		logic lan;
		logic ring;
		logic ps2;
		logic usb;
	} wake_src_t;

	// os power request
	typedef struct packed {
		logic       valid;
		sys_state_t target;
	} os_req_t;

endpackage : pwr_state_pkg

/* sw_model.sv */
// partner: front panel switch with one contact bounce
`timescale 1ns/1ps
`default_nettype none
module sw_model (
	input  wire logic       clk_i,
	input  wire logic       go_i,
	input  wire logic [7:0] len_i,
	output wire logic       sw_n_o
);
	logic [7:0] left = 8'h00;
	logic [7:0] span = 8'h00;
	// hold time countdown
	always @(posedge clk_i) begin
		left <= go_i ? len_i : left - {7'h00, left != 8'h00};
		span <= go_i ? len_i : span;
	end
	// bounce two cycles in, so the debounce is exercised
	assign sw_n_o = left == 8'h00 || left + 8'h02 == span;
endmodule : sw_model
`default_nettype wire

/* tb_board_power_state_wake_control.sv */
// testbench: power state controller directed scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_board_power_state_wake_control;
	import pwr_state_pkg::*;
	logic       core_clk_i = 0, resetn_i = 0, cover_closed_i = 0, intr_clr_i = 0;
	logic       lan_s5_en_i = 0, go = 0, pwr_sw_n, main_pwr_on_o, wake_evt_o, intrusion_o;
	logic [7:0] len = 8'h00;
	wake_src_t  wake_i = '0;
	os_req_t    os_req_i = '0;
	sys_state_t sleep_level_i = ST_S3, state_o;
	int         n_errors = 0, total_checks = 0;
	// 100 MHz
	always #5 core_clk_i = ~core_clk_i;
	pwr_state_ctrl #(.DEB_CYC(4), .LONG_CYC(50)) DUT (.core_clk_i, .resetn_i,
		.pwr_sw_n_i(pwr_sw_n), .cover_closed_i, .wake_i, .os_req_i, .intr_clr_i, .lan_s5_en_i,
		.sleep_level_i, .state_o, .main_pwr_on_o, .wake_evt_o, .intrusion_o);
	sw_model SW (.clk_i(core_clk_i), .go_i(go), .len_i(len), .sw_n_o(pwr_sw_n));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask : cyc
	task press(input logic [7:0] l);
		go <= 1;
		len <= l;
		cyc(1);
		go <= 0;
		cyc(l + 20);
	endtask : press
	// off, on, sleep, on again; held down past the limit; then S0 as sleep target
	task t_switch;
		press(8'd12);
		chk({state_o, main_pwr_on_o}, {ST_S0, 1'b1});
		press(8'd12);
		chk({state_o, main_pwr_on_o}, {ST_S3, 1'b0});
		press(8'd12);
		chk(state_o, ST_S0);
		press(8'd90);
		chk(state_o, ST_S5);
		sleep_level_i <= ST_S0;
		press(8'd12);
		press(8'd12);
		chk({state_o, main_pwr_on_o}, {ST_S1, 1'b1});
		press(8'd90);
		chk({state_o, main_pwr_on_o}, {ST_S5, 1'b0});
		press(8'd12);
		chk(state_o, ST_S0);
		$display("switch test done");
	endtask : t_switch
	// every source against every sleep level, with and without the lan enable
	task t_wake;
		sys_state_t lv[4] = '{ST_S1, ST_S3, ST_S4, ST_S5};
		logic ok;
		for (int e = 0; e < 2; e++) begin
			foreach (lv[i]) begin
				for (int b = 0; b < 7; b++) begin
					if (state_o !== ST_S0) begin
						wake_i.rtc <= 1;
						cyc(5);
						wake_i.rtc <= 0;
						cyc(3);
					end
					lan_s5_en_i <= e[0];
					os_req_i <= '{1'b1, lv[i]};
					cyc(1);
					os_req_i.valid <= 0;
					cyc(4);
					chk(state_o, lv[i]);
					ok = b > 4 || (b > 2 && (lv[i] != ST_S5 || e == 1)) || lv[i] < ST_S4;
					wake_i[b] <= 1;
					cyc(3);
					// the wake report stands one cycle, so look just after it rises
					#1;
					chk({7'h00, wake_evt_o}, {7'h00, ok});
					cyc(3);
					wake_i <= '0;
					cyc(4);
					chk(state_o, ok ? ST_S0 : lv[i]);
				end
			end
		end
		$display("wake test done");
	endtask : t_wake
	// cover closed, clear refused while closed, then flag cleared
	task t_intr;
		cover_closed_i <= 1;
		cyc(6);
		intr_clr_i <= 1;
		cyc(1);
		intr_clr_i <= 0;
		cyc(2);
		chk({7'h00, intrusion_o}, 8'h01);
		cover_closed_i <= 0;
		cyc(6);
		chk({7'h00, intrusion_o}, 8'h01);
		intr_clr_i <= 1;
		cyc(1);
		intr_clr_i <= 0;
		cyc(4);
		chk({7'h00, intrusion_o}, 8'h00);
		$display("intrusion test done");
	endtask : t_intr
	task conclude;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude
	initial begin
		cyc(5);
		resetn_i <= 1;
		cyc(2);
		chk(state_o, ST_S5);
		t_switch();
		t_wake();
		t_intr();
		conclude();
	end
	// hang guard, far past the roughly 1400 cycles needed
	initial begin
		#500_000;
		n_errors++;
		conclude();
	end
endmodule : tb_board_power_state_wake_control
`default_nettype wire
